// ===== shared/ttu_pkg.sv
package ttu_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned CNT_W  = 24;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h00_0000;

  // ----------------------------------------
  // control/status register fields
  // ----------------------------------------
  localparam int unsigned PIN_USE_W = 2;
  localparam int unsigned MODE_W    = 3;
  localparam logic [PIN_USE_W-1:0] PIN_GPIO_IN  = 2'h0;
  localparam logic [PIN_USE_W-1:0] PIN_GPIO_OUT = 2'h1;
  localparam logic [PIN_USE_W-1:0] PIN_TIMER    = 2'h2;
  localparam logic [MODE_W-1:0] MODE_TIMER    = 3'h0;
  localparam logic [MODE_W-1:0] MODE_EVENT    = 3'h1;
  localparam logic [MODE_W-1:0] MODE_MEASURE  = 3'h2;
  localparam logic [MODE_W-1:0] MODE_WATCHDOG = 3'h3;
  localparam logic [MODE_W-1:0] MODE_PWM      = 3'h4;

  typedef struct packed {
    logic                 enable;
    logic [PIN_USE_W-1:0] pin_use;
    logic [MODE_W-1:0]    mode;
    logic                 irq_en;
    logic                 gpio_out;
    logic [CNT_W-1:0]     compare;
  } ttu_ctrl_t;

  localparam ttu_ctrl_t CTRL_RESET = '{enable: 1'b0, pin_use: PIN_GPIO_IN, mode: MODE_TIMER,
                                       irq_en: 1'b0, gpio_out: 1'b0, compare: CNT_RESET};

  typedef struct packed {
    logic             reached;
    logic             pin_in;
    logic [CNT_W-1:0] count;
  } ttu_stat_t;

  typedef struct packed {
    logic o;
    logic oe;
  } ttu_pin_t;
endpackage

// ===== logic/ttu_channel.sv
module ttu_channel
  import ttu_pkg::*;
(
  // clock and reset
  input  wire logic      clock,
  input  wire logic      rst_b,
  // control/status
  input  wire ttu_ctrl_t ctrl,
  input  wire logic      ctrl_wr,
  input  wire logic      clear_reached,
  output ttu_stat_t      stat,
  output logic           irq,
  // pin
  input  wire logic      pin_i,
  output ttu_pin_t       pin
);
  import ttu_pkg::*;

  ttu_ctrl_t        ctrl_q;
  logic [CNT_W-1:0] count_q;
  logic             pin_q;
  logic             reached_q;
  logic             out_q;
  logic             tick;
  logic             hit;
  logic             ext_src;
  logic             drives;

  // ----------------------------------------
  // control/status register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl;
    end
  end

  // ----------------------------------------
  // count source
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_i;
    end
  end

  // external events counted on rising pin edges; internal on every clock
  assign ext_src = (ctrl_q.mode == MODE_EVENT) || (ctrl_q.mode == MODE_MEASURE);
  assign tick    = ctrl_q.enable && (ext_src ? (pin_i && !pin_q) : 1'b1);
  assign hit     = tick && (count_q == ctrl_q.compare);

  always_ff @(posedge clock) begin
    if (!rst_b || ctrl_wr) begin
      count_q <= CNT_RESET;
    end else if (hit) begin
      count_q <= CNT_RESET;
    end else if (tick) begin
      count_q <= count_q + 24'h00_0001;
    end
  end

  // ----------------------------------------
  // reached flag; a new hit beats the clear
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reached_q <= 1'b0;
    end else if (hit) begin
      reached_q <= 1'b1;
    end else if (clear_reached) begin
      reached_q <= 1'b0;
    end
  end

  assign irq = reached_q && ctrl_q.irq_en;

  // ----------------------------------------
  // pin output
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_b || ctrl_wr) begin
      out_q <= 1'b0;
    end else if (hit && !ext_src) begin
      out_q <= (ctrl_q.mode == MODE_PWM) ? !out_q : 1'b1;
    end
  end

  // timer use drives only in output modes; input modes leave the pin alone
  assign drives = (ctrl_q.pin_use == PIN_GPIO_OUT) ||
                  ((ctrl_q.pin_use == PIN_TIMER) && !ext_src);
  assign pin.oe = drives;
  assign pin.o  = (ctrl_q.pin_use == PIN_GPIO_OUT) ? ctrl_q.gpio_out : out_q;

  assign stat.reached = reached_q;
  assign stat.pin_in  = pin_q;
  assign stat.count   = count_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reset_input;
    @(posedge clock) $fell(rst_b) |=> !pin.oe;
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pin driven after reset");

  property p_input_modes;
    @(posedge clock) disable iff (!rst_b)
      (ctrl_q.pin_use == PIN_TIMER && ext_src) |-> !pin.oe;
  endproperty
  a_input_modes: assert property (p_input_modes) else $error("input mode drives pin");

  property p_output_modes;
    @(posedge clock) disable iff (!rst_b)
      (ctrl_q.pin_use == PIN_TIMER && !ext_src) |-> pin.oe;
  endproperty
  a_output_modes: assert property (p_output_modes) else $error("output mode not driving");

  property p_write_takes;
    @(posedge clock) disable iff (!rst_b)
      ctrl_wr |=> (ctrl_q == $past(ctrl));
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("control write lost");

  property p_hit_sets;
    @(posedge clock) disable iff (!rst_b) hit |=> reached_q;
  endproperty
  a_hit_sets: assert property (p_hit_sets) else $error("reached not set");

  property p_sticky;
    @(posedge clock) disable iff (!rst_b)
      (reached_q && !clear_reached) |=> reached_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("reached dropped");

  property p_irq;
    @(posedge clock) disable iff (!rst_b)
      (hit && ctrl_q.irq_en && !ctrl_wr) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_ext_count;
    @(posedge clock) disable iff (!rst_b)
      (ctrl_q.enable && ext_src && !pin_i && !ctrl_wr) |=> $stable(count_q);
  endproperty
  a_ext_count: assert property (p_ext_count) else $error("count moved without event");

  property p_out_set;
    @(posedge clock) disable iff (!rst_b)
      (hit && ctrl_q.mode == MODE_TIMER && !ctrl_wr) |=> out_q;
  endproperty
  a_out_set: assert property (p_out_set) else $error("timer output not set");
endmodule

// ===== logic/ttu_top.sv
// Operation
// - three identical channels, each fully independent
// - count internal clock or pin events
// - interrupt after programmed count reached
// - drive pin after programmed internal count
// - event and measurement modes leave pin undriven in timer pin use
// - watchdog, timer, pulse modes drive pin in timer pin use
// - after reset pin is general input
// - control write selects gpio out or timer
module ttu_top
  import ttu_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  // control/status per channel
  input  wire ttu_ctrl_t             timer_ctrl_status_0,
  input  wire ttu_ctrl_t             timer_ctrl_status_1,
  input  wire ttu_ctrl_t             timer_ctrl_status_2,
  input  wire logic [NUM_CH-1:0]     ctrl_wr,
  input  wire logic [NUM_CH-1:0]     clear_reached,
  output ttu_stat_t [NUM_CH-1:0]     stat,
  output logic      [NUM_CH-1:0]     irq,
  // timer pins
  input  wire logic                  timer_pin_0_i,
  input  wire logic                  timer_pin_1_i,
  input  wire logic                  timer_pin_2_i,
  output ttu_pin_t                   timer_pin_0,
  output ttu_pin_t                   timer_pin_1,
  output ttu_pin_t                   timer_pin_2
);
  import ttu_pkg::*;

  ttu_ctrl_t [NUM_CH-1:0] ctrl_v;
  logic      [NUM_CH-1:0] pin_in_v;
  ttu_pin_t  [NUM_CH-1:0] pin_v;

  assign ctrl_v   = {timer_ctrl_status_2, timer_ctrl_status_1, timer_ctrl_status_0};
  assign pin_in_v = {timer_pin_2_i, timer_pin_1_i, timer_pin_0_i};
  assign timer_pin_0 = pin_v[0];
  assign timer_pin_1 = pin_v[1];
  assign timer_pin_2 = pin_v[2];

  // ----------------------------------------
  // channels share nothing but clock and reset
  // ----------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    ttu_channel u_ch (
      .clock         (clock),
      .rst_b         (rst_b),
      .ctrl          (ctrl_v[g]),
      .ctrl_wr       (ctrl_wr[g]),
      .clear_reached (clear_reached[g]),
      .stat          (stat[g]),
      .irq           (irq[g]),
      .pin_i         (pin_in_v[g]),
      .pin           (pin_v[g])
    );
  end
endmodule

// ===== dv/ttu_pin_model.sv
module ttu_pin_model
  import ttu_pkg::*;
(
  // pin and far-side source
  input  wire ttu_pin_t pin,
  input  wire logic     ev,
  output logic          pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // source yields while the channel drives; it never floats, so no stale level
  assign pin_i = pin.oe ? pin.o : ev;
endmodule

// ===== dv/tb_ttu_top.sv
module tb_ttu_top
  import ttu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [MODE_W-1:0]    mode;
    logic [PIN_USE_W-1:0] pin_use;
    logic [CNT_W-1:0]     cmp;
    logic                 oe;
  } ttu_row_t;
  // -------------------------
  // signals
  // -------------------------
  logic                   clock = 1'b0;
  logic                   rst_b = 1'b0;
  ttu_ctrl_t              ctl [NUM_CH] = '{CTRL_RESET, CTRL_RESET, CTRL_RESET};
  logic      [NUM_CH-1:0] wr = '0, clr = '0, ev = '0, pin_i, irq;
  ttu_stat_t [NUM_CH-1:0] stat;
  ttu_pin_t               pin [NUM_CH];
  int                     error_cnt = 0, cmp_count = 0;
  // compare of 1 would re-hit on the CTRL_RESET write edge, so output rows use 2 or more
  ttu_row_t rows [7] = '{'{MODE_TIMER, PIN_TIMER, 24'h00_0002, 1'b1},
    '{MODE_WATCHDOG, PIN_TIMER, 24'h00_0003, 1'b1}, '{MODE_PWM, PIN_TIMER, 24'h00_0002, 1'b1},
    '{MODE_EVENT, PIN_TIMER, 24'h00_0002, 1'b0}, '{MODE_MEASURE, PIN_TIMER, 24'h00_0001, 1'b0},
    '{MODE_TIMER, PIN_GPIO_OUT, 24'h00_0002, 1'b1}, '{MODE_EVENT, PIN_GPIO_IN, 24'h00_0002, 1'b0}};
  always #10 clock = ~clock;
  ttu_top u_ttu_top (.clock(clock), .rst_b(rst_b), .timer_ctrl_status_0(ctl[0]),
    .timer_ctrl_status_1(ctl[1]), .timer_ctrl_status_2(ctl[2]), .ctrl_wr(wr),
    .clear_reached(clr), .stat(stat), .irq(irq), .timer_pin_0_i(pin_i[0]),
    .timer_pin_1_i(pin_i[1]), .timer_pin_2_i(pin_i[2]), .timer_pin_0(pin[0]),
    .timer_pin_1(pin[1]), .timer_pin_2(pin[2]));
  for (genvar g = 0; g < NUM_CH; g++) begin : g_pin
    ttu_pin_model u_ttu_pin_model (.pin(pin[g]), .ev(ev[g]), .pin_i(pin_i[g]));
  end
  // -------------------------
  // tasks
  // -------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr_ch(input int ch, input ttu_ctrl_t c);
    @(posedge clock);
    ctl[ch] <= c;
    wr[ch]  <= 1'b1;
    @(posedge clock);
    wr[ch] <= 1'b0;
    #1;
  endtask
  task automatic pulse(input int ch);
    @(posedge clock);
    ev[ch] <= 1'b1;
    @(posedge clock);
    ev[ch] <= 1'b0;
    tick(3);
  endtask
  task automatic clear(input int ch);
    @(posedge clock);
    clr[ch] <= 1'b1;
    @(posedge clock);
    clr[ch] <= 1'b0;
    #1;
  endtask
  task automatic step(input int ch, input logic evm);
    if (evm) pulse(ch);
    else tick(1);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // -------------------------
  // sequence
  // -------------------------
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    ttu_ctrl_t c;
    int        ch;
    logic      evm;
    tick(7);
    chk({pin[0].oe, pin[1].oe, pin[2].oe, irq}, 0);
    @(posedge clock);
    rst_b <= 1'b1;
    tick(1);
    chk({pin[0].oe, pin[1].oe, pin[2].oe, stat === '0}, 1);
    for (int i = 0; i < 7; i++) begin
      ch = i % NUM_CH;
      evm = rows[i].mode inside {MODE_EVENT, MODE_MEASURE};
      c = CTRL_RESET;
      c.enable = rows[i].pin_use == PIN_TIMER;
      c.pin_use = rows[i].pin_use;
      c.mode = rows[i].mode;
      c.irq_en = 1'b1;
      c.gpio_out = 1'b1;
      c.compare = rows[i].cmp;
      wr_ch(ch, c);
      chk(pin[ch].oe, rows[i].oe);
      if (c.enable) begin
        for (int k = 0; k < rows[i].cmp; k++) step(ch, evm);
        chk({stat[ch].reached, stat[ch].count}, rows[i].cmp);
        step(ch, evm);
        chk({stat[ch].reached, irq[ch], stat[(ch+1)%NUM_CH].reached}, 3'h6);
        chk(pin[ch].o, rows[i].oe);
        if (evm) begin
          tick(4);
          chk(irq[ch], 1);
        end
      end else begin
        chk(pin[ch].o & pin[ch].oe, rows[i].oe);
        @(posedge clock);
        ev[ch] <= 1'b1;
        tick(2);
        chk(stat[ch].pin_in, 1);
        @(posedge clock);
        ev[ch] <= 1'b0;
      end
      wr_ch(ch, CTRL_RESET);
      clear(ch);
      chk({stat[ch].reached, irq[ch]}, 0);
    end
    // a hit on the clear edge must win
    c = CTRL_RESET;
    c.enable = 1'b1;
    c.pin_use = PIN_TIMER;
    c.mode = MODE_PWM;
    c.irq_en = 1'b1;
    wr_ch(2, c);
    tick(1);
    clear(2);
    chk(stat[2].reached, 1);
    // compare 0 hits every clock, so pulse mode flips the pin each cycle
    evm = pin[2].o;
    tick(1);
    chk(pin[2].o, !evm);
    @(posedge clock);
    rst_b <= 1'b0;
    tick(2);
    chk({pin[0].oe, pin[1].oe, pin[2].oe, irq, stat === '0}, 1);
    // channel 1 must run again after a mid-run reset
    @(posedge clock);
    rst_b <= 1'b1;
    wr_ch(1, c);
    tick(1);
    chk({stat[1].reached, irq[1], pin[1].oe}, 7);
    end_of_test();
  end
endmodule
